/* shared/mac_table_pkg.sv */
/*
  Constants for the address table access engine: register offsets, command
  and status encodings, table entry layouts and timing counts.
  Assumes a 200 MHz core clock and 10-bit register addresses.
*/
package mac_table_pkg;
  // register offsets and reset values
  localparam logic [9:0] CSR_OFS = 10'h2B0;
  localparam logic [9:0] PORT_OFS = 10'h2B1;
  localparam logic [9:0] MAC_LO_OFS = 10'h2B2;
  localparam logic [9:0] MAC_MID_OFS = 10'h2B3;
  localparam logic [9:0] MAC_HI_OFS = 10'h2B4;
  localparam logic [9:0] ATTR_OFS = 10'h2B5;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [4:0] CMD_RESET = 5'h00;

  // control/status and attribute register layout
  localparam int CSR_BUSY_BIT = 15;
  localparam int CSR_STAT_LSB = 13;
  localparam int CMD_W = 5;
  localparam int CMD_TBL_LSB = 3;
  localparam int ATTR_STATIC_BIT = 0;
  localparam int ATTR_IGMP_BIT = 12;

  // command field: bits 2:0 operation, bits 4:3 target table
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_DELETE = 3'h2;
  localparam logic [2:0] OP_SEARCH = 3'h3;
  localparam logic [2:0] OP_READ = 3'h4;
  localparam logic [2:0] OP_CLEAR = 3'h5;
  localparam logic [1:0] TBL_UC = 2'h0;
  localparam logic [1:0] TBL_MC = 2'h1;
  localparam logic [1:0] TBL_IG = 2'h2;

  // result codes
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_NOT_FOUND = 2'h1;
  localparam logic [1:0] ST_FULL = 2'h2;
  localparam logic [1:0] ST_REJECT = 2'h3;

  // address table entry: valid, mcast, static, igmp, port map, mac
  localparam int UC_ENTRIES = 2048;
  localparam int PORT_W = 3;
  localparam int MAC_W = 48;
  localparam int ENTRY_W = 55;
  localparam int E_VALID = 54;
  localparam int E_MCAST = 53;
  localparam int E_STATIC = 52;
  localparam int E_IGMP = 51;
  localparam int E_PORT_LSB = 48;

  // membership entry: valid[2:0], timers[5:0], port map, table address
  localparam int IG_ENTRIES = 32;
  localparam int IG_W = 23;
  localparam int IG_VALID_LSB = 20;
  localparam int IG_TIMER_LSB = 14;
  localparam int IG_PORT_LSB = 11;
  localparam int IG_ADDR_W = 11;
  localparam logic [2:0] IG_VALID_INIT = 3'h7;
  localparam logic [5:0] IG_TIMER_INIT = 6'h3F;

  // timing
  localparam int CORE_PERIOD_NS = 5;
  localparam int CLEAR_TIME_NS = 4500000;
  localparam int CLEAR_CYCLES = CLEAR_TIME_NS / CORE_PERIOD_NS;
endpackage

/* logic/mac_table_ram.sv */
/*
  Single-port synchronous table memory with registered read data.
  Assumes the caller holds the address one cycle to get read data.
*/
module mac_table_ram #(
  parameter int WIDTH = 55,
  parameter int DEPTH = 2048,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr,
  input wire logic [WIDTH-1:0] i_wdata,
  output logic [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // no reset: the engine sweeps the address table clear after reset; membership slots are gated by used bits
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule

/* logic/mac_table_engine.sv */
/*
  Access engine for the shared unicast/multicast address table and the
  membership table. Holds the control/status and data registers.
  Assumes the register port and the learn/snoop requests come from logic
  on the core clock; the table is swept clear after each reset.
*/
// Operation
// - 2048 unicast entries, oldest evicted when full
// - multicast shares storage, static, newest replaces eldest
// - snooping engine may also write multicast entries
// - 32 membership entries, host reads, full drops joins
// - table commands; membership table: write, delete, read
// - busy on bit 15; host waits for idle
// - command write to bits 4:0 launches operation
// - result code in bits 14:13 after busy clears
// - search returns port, sequence, attributes
// - read returns port, mac or memory address
// - membership read returns valid, timers; igmp flag
// - clear needs no data, done within 4.5ms
module mac_table_engine
  import mac_table_pkg::*;
#(
  parameter int CLEAR_LIMIT_CYCLES = CLEAR_CYCLES,
  parameter int UC_DEPTH = UC_ENTRIES,
  parameter int IG_DEPTH = IG_ENTRIES
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  input wire logic [9:0] i_REG_ADDR,
  input wire logic i_REG_WR,
  input wire logic i_REG_RD,
  input wire logic [15:0] i_REG_WDATA,
  output logic [15:0] o_REG_RDATA,
  input wire logic i_LEARN_REQ,
  input wire logic [47:0] i_LEARN_MAC,
  input wire logic [2:0] i_LEARN_PORT,
  input wire logic i_IGMP_HW_EN,
  input wire logic i_IGMP_JOIN,
  input wire logic [47:0] i_IGMP_MAC,
  input wire logic [2:0] i_IGMP_PORT,
  output logic o_ENGINE_READY,
  output logic o_IGMP_FULL
);
  localparam int AW = $clog2(UC_DEPTH);
  localparam int IAW = $clog2(IG_DEPTH);

  typedef enum logic [2:0] {
    S_IDLE, S_SCAN_RD, S_SCAN_CMP, S_RD_WAIT, S_RD_OUT, S_WR, S_CLR
  } state_t;

  state_t state_reg, state_next;
  logic [CMD_W-1:0] cmd_reg, cmd_next;
  logic [1:0] status_reg, status_next;
  logic [15:0] port_reg, port_next, d1_reg, d1_next, d2_reg, d2_next;
  logic [15:0] d3_reg, d3_next, attr_reg, attr_next;
  logic [AW-1:0] idx_reg, idx_next, ring_reg, ring_next;
  logic [ENTRY_W-1:0] wr_entry_reg, wr_entry_next;
  logic [IG_W-1:0] ig_entry_reg, ig_entry_next;
  logic [IAW-1:0] ig_idx_reg, ig_idx_next;
  logic [IG_DEPTH-1:0] used_reg, used_next;
  logic wr_tbl_reg, wr_tbl_next, wr_ig_reg, wr_ig_next, insert_reg, insert_next;
  logic [15:0] rdata_reg;
  logic [ENTRY_W-1:0] tbl_rdata;
  logic [IG_W-1:0] ig_rdata;

  function automatic logic cmd_legal(input logic [CMD_W-1:0] c);
    logic [2:0] op;
    logic [1:0] tb;
    op = c[2:0];
    tb = c[CMD_W-1:CMD_TBL_LSB];
    if (tb == TBL_UC || tb == TBL_MC) begin
      cmd_legal = (op >= OP_WRITE) && (op <= OP_CLEAR);
    end else if (tb == TBL_IG) begin
      cmd_legal = (op == OP_WRITE) || (op == OP_DELETE) || (op == OP_READ);
    end else begin
      cmd_legal = 1'b0;
    end
  endfunction

  function automatic logic [IAW-1:0] first_free(input logic [IG_DEPTH-1:0] u);
    first_free = '0;
    for (int i = IG_DEPTH - 1; i >= 0; i--) begin
      if (!u[i]) begin
        first_free = IAW'(i);
      end
    end
  endfunction

  wire idle = (state_reg == S_IDLE);
  wire busy = !idle;
  wire csr_hit = (i_REG_ADDR == CSR_OFS);
  wire launch = idle && i_REG_WR && csr_hit;
  wire [2:0] op = cmd_reg[2:0];
  wire [1:0] tsel = cmd_reg[CMD_W-1:CMD_TBL_LSB];
  wire [2:0] new_op = i_REG_WDATA[2:0];
  wire [1:0] new_tsel = i_REG_WDATA[CMD_W-1:CMD_TBL_LSB];
  wire ig_full = &used_reg;
  wire join_go = idle && !launch && i_IGMP_HW_EN && i_IGMP_JOIN && !ig_full;
  wire learn_go = idle && !launch && !(i_IGMP_HW_EN && i_IGMP_JOIN) && i_LEARN_REQ;
  wire [IAW-1:0] free_slot = first_free(used_reg);
  wire [MAC_W-1:0] host_mac = {d3_reg, d2_reg, d1_reg};
  wire want_mc = (tsel == TBL_MC);
  wire last_idx = (idx_reg == AW'(UC_DEPTH - 1));
  wire [PORT_W-1:0] rd_port = tbl_rdata[E_PORT_LSB +: PORT_W];
  wire hit = tbl_rdata[E_VALID] && (tbl_rdata[E_MCAST] == want_mc)
    && (tbl_rdata[MAC_W-1:0] == host_mac);
  // multicast entries are always static
  wire new_static = want_mc | attr_reg[ATTR_STATIC_BIT];
  wire [ENTRY_W-1:0] host_entry = {1'b1, want_mc, new_static, 1'b0,
    port_reg[PORT_W-1:0], host_mac};
  wire tbl_we = (state_reg == S_WR && wr_tbl_reg) || (state_reg == S_CLR);
  wire [ENTRY_W-1:0] tbl_wdata = (state_reg == S_CLR) ? '0 : wr_entry_reg;
  wire ig_we = (state_reg == S_WR) && wr_ig_reg;
  wire [15:0] csr_view = {busy, status_reg, 8'h00, cmd_reg};
  wire [15:0] rd_mux =
    (i_REG_ADDR == CSR_OFS) ? csr_view :
    (i_REG_ADDR == PORT_OFS) ? port_reg :
    (i_REG_ADDR == MAC_LO_OFS) ? d1_reg :
    (i_REG_ADDR == MAC_MID_OFS) ? d2_reg :
    (i_REG_ADDR == MAC_HI_OFS) ? d3_reg :
    (i_REG_ADDR == ATTR_OFS) ? attr_reg : 16'h0000;

  assign o_ENGINE_READY = idle && !launch;
  assign o_IGMP_FULL = ig_full;
  assign o_REG_RDATA = rdata_reg;

  mac_table_ram #(.WIDTH(ENTRY_W), .DEPTH(UC_DEPTH), .AW(AW)) u_tbl (
    .i_clk(I_CORE_CLK),
    .i_we(tbl_we),
    .i_addr(idx_reg),
    .i_wdata(tbl_wdata),
    .o_rdata(tbl_rdata)
  );

  mac_table_ram #(.WIDTH(IG_W), .DEPTH(IG_DEPTH), .AW(IAW)) u_ig (
    .i_clk(I_CORE_CLK),
    .i_we(ig_we),
    .i_addr(ig_idx_reg),
    .i_wdata(ig_entry_reg),
    .o_rdata(ig_rdata)
  );

  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    status_next = status_reg;
    port_next = port_reg;
    d1_next = d1_reg;
    d2_next = d2_reg;
    d3_next = d3_reg;
    attr_next = attr_reg;
    idx_next = idx_reg;
    ring_next = ring_reg;
    wr_entry_next = wr_entry_reg;
    ig_entry_next = ig_entry_reg;
    ig_idx_next = ig_idx_reg;
    used_next = used_reg;
    wr_tbl_next = wr_tbl_reg;
    wr_ig_next = wr_ig_reg;
    insert_next = insert_reg;
    // data registers accept host writes only while idle
    if (idle && i_REG_WR) begin
      if (i_REG_ADDR == PORT_OFS) port_next = i_REG_WDATA;
      if (i_REG_ADDR == MAC_LO_OFS) d1_next = i_REG_WDATA;
      if (i_REG_ADDR == MAC_MID_OFS) d2_next = i_REG_WDATA;
      if (i_REG_ADDR == MAC_HI_OFS) d3_next = i_REG_WDATA;
      if (i_REG_ADDR == ATTR_OFS) attr_next = i_REG_WDATA;
    end
    unique case (state_reg)
      S_IDLE: begin
        if (launch) begin
          cmd_next = i_REG_WDATA[CMD_W-1:0];
          status_next = ST_OK;
          if (!cmd_legal(i_REG_WDATA[CMD_W-1:0])) begin
            status_next = ST_REJECT;
          end else if (new_tsel == TBL_IG) begin
            if (new_op == OP_READ) begin
              ig_idx_next = d1_reg[IAW-1:0];
              state_next = S_RD_WAIT;
            end else if (new_op == OP_DELETE) begin
              if (!used_reg[d1_reg[IAW-1:0]]) status_next = ST_NOT_FOUND;
              used_next[d1_reg[IAW-1:0]] = 1'b0;
            end else if (ig_full) begin
              status_next = ST_FULL;
            end else begin
              ig_idx_next = free_slot;
              d1_next = {{(16 - IAW){1'b0}}, free_slot};
              ig_entry_next = {d2_reg[2:0], d3_reg[5:0], port_reg[PORT_W-1:0],
                {IG_ADDR_W{1'b0}}};
              used_next[free_slot] = 1'b1;
              wr_tbl_next = 1'b0;
              wr_ig_next = 1'b1;
              insert_next = 1'b0;
              state_next = S_WR;
            end
          end else if (new_op == OP_READ) begin
            idx_next = d1_reg[AW-1:0];
            state_next = S_RD_WAIT;
          end else if (new_op == OP_CLEAR) begin
            idx_next = '0;
            state_next = S_CLR;
          end else begin
            idx_next = '0;
            state_next = S_SCAN_RD;
          end
        end else if (join_go) begin
          wr_entry_next = {1'b1, 1'b1, 1'b1, 1'b1, i_IGMP_PORT, i_IGMP_MAC};
          ig_entry_next = {IG_VALID_INIT, IG_TIMER_INIT, i_IGMP_PORT, ring_reg};
          idx_next = ring_reg;
          ig_idx_next = free_slot;
          used_next[free_slot] = 1'b1;
          wr_tbl_next = 1'b1;
          wr_ig_next = 1'b1;
          insert_next = 1'b1;
          state_next = S_WR;
        end else if (learn_go) begin
          wr_entry_next = {1'b1, 1'b0, 1'b0, 1'b0, i_LEARN_PORT, i_LEARN_MAC};
          idx_next = ring_reg;
          wr_tbl_next = 1'b1;
          wr_ig_next = 1'b0;
          insert_next = 1'b1;
          state_next = S_WR;
        end
      end
      S_SCAN_RD: state_next = S_SCAN_CMP;
      S_SCAN_CMP: begin
        wr_tbl_next = 1'b1;
        wr_ig_next = 1'b0;
        insert_next = 1'b0;
        if (hit) begin
          state_next = S_WR;
          if (op == OP_WRITE) begin
            wr_entry_next = host_entry;
            wr_entry_next[E_IGMP] = tbl_rdata[E_IGMP];
          end else if (op == OP_DELETE) begin
            wr_entry_next = '0;
          end else begin
            port_next = {13'h0000, rd_port};
            d1_next = {{(16 - AW){1'b0}}, idx_reg};
            attr_next = 16'h0000;
            attr_next[ATTR_STATIC_BIT] = !want_mc && tbl_rdata[E_STATIC];
            attr_next[ATTR_IGMP_BIT] = want_mc && tbl_rdata[E_IGMP];
            state_next = S_IDLE;
          end
        end else if (!last_idx) begin
          idx_next = idx_reg + 1'b1;
          state_next = S_SCAN_RD;
        end else if (op == OP_WRITE) begin
          // a miss takes the ring slot, overwriting the eldest entry
          wr_entry_next = host_entry;
          idx_next = ring_reg;
          insert_next = 1'b1;
          state_next = S_WR;
        end else begin
          status_next = ST_NOT_FOUND;
          state_next = S_IDLE;
        end
      end
      S_RD_WAIT: state_next = S_RD_OUT;
      S_RD_OUT: begin
        state_next = S_IDLE;
        if (tsel == TBL_IG) begin
          if (!used_reg[ig_idx_reg]) begin
            status_next = ST_NOT_FOUND;
          end else begin
            port_next = {13'h0000, ig_rdata[IG_PORT_LSB +: PORT_W]};
            d1_next = {5'h00, ig_rdata[IG_ADDR_W-1:0]};
            d2_next = {13'h0000, ig_rdata[IG_VALID_LSB +: 3]};
            d3_next = {10'h000, ig_rdata[IG_TIMER_LSB +: 6]};
          end
        end else if (!tbl_rdata[E_VALID] || tbl_rdata[E_MCAST] != want_mc) begin
          status_next = ST_NOT_FOUND;
        end else begin
          port_next = {13'h0000, rd_port};
          {d3_next, d2_next, d1_next} = tbl_rdata[MAC_W-1:0];
          attr_next = 16'h0000;
          attr_next[ATTR_STATIC_BIT] = !want_mc && tbl_rdata[E_STATIC];
          attr_next[ATTR_IGMP_BIT] = want_mc && tbl_rdata[E_IGMP];
        end
      end
      S_WR: begin
        if (insert_reg) ring_next = ring_reg + 1'b1;
        state_next = S_IDLE;
      end
      S_CLR: begin
        idx_next = idx_reg + 1'b1;
        if (last_idx) begin
          ring_next = '0;
          state_next = S_IDLE;
        end
      end
    endcase
  end

  // reset starts in the clear sweep so that no stale valid bit survives
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_reg <= S_CLR;
      cmd_reg <= CMD_RESET;
      status_reg <= ST_OK;
      port_reg <= DATA_RESET;
      d1_reg <= DATA_RESET;
      d2_reg <= DATA_RESET;
      d3_reg <= DATA_RESET;
      attr_reg <= DATA_RESET;
      idx_reg <= '0;
      ring_reg <= '0;
      used_reg <= '0;
    end else begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      status_reg <= status_next;
      port_reg <= port_next;
      d1_reg <= d1_next;
      d2_reg <= d2_next;
      d3_reg <= d3_next;
      attr_reg <= attr_next;
      idx_reg <= idx_next;
      ring_reg <= ring_next;
      used_reg <= used_next;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      wr_entry_reg <= '0;
      ig_entry_reg <= '0;
      ig_idx_reg <= '0;
      wr_tbl_reg <= 1'b0;
      wr_ig_reg <= 1'b0;
      insert_reg <= 1'b0;
      rdata_reg <= DATA_RESET;
    end else begin
      wr_entry_reg <= wr_entry_next;
      ig_entry_reg <= ig_entry_next;
      ig_idx_reg <= ig_idx_next;
      wr_tbl_reg <= wr_tbl_next;
      wr_ig_reg <= wr_ig_next;
      insert_reg <= insert_next;
      if (i_REG_RD) rdata_reg <= rd_mux;
    end
  end

  // helper: length of the current clear sweep
  logic [19:0] clr_cnt;
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      clr_cnt <= '0;
    end else begin
      clr_cnt <= (state_reg == S_CLR) ? clr_cnt + 1'b1 : '0;
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_B);

  sequence read_launch_s;
    launch && cmd_legal(i_REG_WDATA[CMD_W-1:0]) && new_op == OP_READ
      && new_tsel == TBL_UC;
  endsequence
  sequence read_done_s;
    ##3 idle;
  endsequence

  // membership delete and a membership write into a full table finish in the launch cycle
  busy_launch_a: assert property (launch && cmd_legal(i_REG_WDATA[CMD_W-1:0])
    && !(new_tsel == TBL_IG && new_op == OP_DELETE)
    && !(new_tsel == TBL_IG && new_op == OP_WRITE && ig_full) |=> busy)
    else $error("legal command did not raise busy");
  busy_bit_a: assert property (i_REG_RD && csr_hit
    |=> o_REG_RDATA[CSR_BUSY_BIT] == $past(busy))
    else $error("busy bit does not mirror engine state");
  status_read_a: assert property (i_REG_RD && csr_hit
    |=> o_REG_RDATA[CSR_STAT_LSB +: 2] == $past(status_reg))
    else $error("status field wrong on read");
  // only a search hit or a finished read may load data register 1 while busy
  busy_hold_a: assert property (busy && i_REG_WR && state_reg != S_RD_OUT
    && !(state_reg == S_SCAN_CMP && hit) |=> $stable(d1_reg))
    else $error("busy write disturbed data");
  busy_cmd_a: assert property (busy && i_REG_WR && csr_hit |=> $stable(cmd_reg))
    else $error("command accepted while busy");
  reject_a: assert property (launch && new_tsel == TBL_IG && new_op == OP_SEARCH
    |=> status_reg == ST_REJECT && idle)
    else $error("illegal membership command not rejected");
  ig_full_a: assert property (ig_full && i_IGMP_JOIN |=> $stable(used_reg))
    else $error("join admitted into full membership table");
  snoop_gate_a: assert property (idle && i_IGMP_JOIN && !i_IGMP_HW_EN
    && !i_LEARN_REQ && !launch |=> idle)
    else $error("join taken while snooping disabled");
  evict_a: assert property (state_reg == S_WR && insert_reg
    |=> ring_reg == $past(ring_reg) + 1'b1)
    else $error("insert did not advance eviction pointer");
  mc_static_a: assert property (tbl_we && tbl_wdata[E_MCAST] |-> tbl_wdata[E_STATIC])
    else $error("multicast entry written non-static");
  clear_time_a: assert property (clr_cnt < 20'(CLEAR_LIMIT_CYCLES))
    else $error("clear exceeds its time limit");
  read_time_a: assert property (read_launch_s |-> read_done_s)
    else $error("table read did not finish in three cycles");
endmodule

/* tb/mgmt_host.sv */
/*
  Host processor model on the engine's register strobe bus: single
  register writes and reads, bounded busy polling, command launch.
  Assumes one caller at a time and the clock shared with the engine.
*/
module mgmt_host
  import mac_table_pkg::*;
#(
  parameter int CLEAR_WAIT = 3000
) (
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  output logic [9:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_addr = 10'h3FF;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 16'hFFFF;
  end
  // released lines flip to the inverse so a stale value is never reused
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk);
    #1;
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    @(posedge i_clk);
    #1;
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk);
    #1;
    o_rd = 1'b0;
    o_addr = ~a;
    @(posedge i_clk);
    #1;
    d = i_rdata;
  endtask
  task automatic wait_idle(input int tries, output logic ok);
    logic [15:0] v;
    ok = 1'b0;
    for (int i = 0; i < tries && ok !== 1'b1; i++) begin
      rd(CSR_OFS, v);
      ok = (v[CSR_BUSY_BIT] === 1'b0);
    end
  endtask
  task automatic cmd(input logic [4:0] c, output logic [1:0] st, output logic ok);
    logic [15:0] v;
    wr(CSR_OFS, {11'h000, c});
    // a clear gets its full time first, then must already be idle
    if (c[2:0] == OP_CLEAR) begin
      repeat (CLEAR_WAIT) @(posedge i_clk);
      wait_idle(1, ok);
    end else begin
      wait_idle(3000, ok);
    end
    rd(CSR_OFS, v);
    st = v[CSR_STAT_LSB +: 2];
  endtask
endmodule

/* tb/test_mac_address_table_access_engine.sv */
/*
  Self-checking bench for the table engine: a host model on the register
  bus, learn and join requests from here, an associative table model.
  Assumes reset sweep and clear finish within the host poll bounds.
*/
module test_mac_address_table_access_engine
  import mac_table_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CLR_WAIT = 3000;
  logic clk, rst_b, wr, rd, lreq, jreq, hw_en, ready, ig_full;
  logic [9:0] addr;
  logic [15:0] wdata, rdata;
  logic [47:0] lmac, jmac;
  logic [2:0] lport, jport;
  logic [31:0] seed = 32'h400D;
  logic [5:0] mdl [logic [47:0]];  // igmp, mcast, static, port
  int ig_used = 0;
  int num_errors = 0;
  int check_count = 0;
  mac_table_engine #(.CLEAR_LIMIT_CYCLES(CLR_WAIT)) uut (
    .I_CORE_CLK(clk), .I_RST_B(rst_b), .i_REG_ADDR(addr), .i_REG_WR(wr), .i_REG_RD(rd),
    .i_REG_WDATA(wdata), .o_REG_RDATA(rdata), .i_LEARN_REQ(lreq), .i_LEARN_MAC(lmac),
    .i_LEARN_PORT(lport), .i_IGMP_HW_EN(hw_en), .i_IGMP_JOIN(jreq), .i_IGMP_MAC(jmac),
    .i_IGMP_PORT(jport), .o_ENGINE_READY(ready), .o_IGMP_FULL(ig_full));
  mgmt_host #(.CLEAR_WAIT(CLR_WAIT)) host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic new_mac(output logic [47:0] m);
    seed = lfsr(seed);
    m[47:32] = seed[15:0] & 16'hFEFF;
    seed = lfsr(seed);
    m[31:0] = seed;
  endtask
  task automatic do_cmd(input logic [4:0] c, output logic [1:0] st);
    logic ok;
    host.cmd(c, st, ok);
    check(16'(ok), 16'h0001);
    if (ok !== 1'b1) print_verdict();
  endtask
  task automatic idle_or_quit();
    logic ok;
    host.wait_idle(3000, ok);
    check(16'(ok), 16'h0001);
    if (ok !== 1'b1) print_verdict();
  endtask
  task automatic load(input logic [47:0] m, input logic [15:0] p, input logic [15:0] a);
    idle_or_quit();
    for (int k = 0; k < 3; k++) host.wr(MAC_LO_OFS + 10'(k), m[16*k +: 16]);
    host.wr(PORT_OFS, p);
    host.wr(ATTR_OFS, a);
  endtask
  task automatic write_entry(input logic [47:0] m, input logic [2:0] p, input logic s,
                             input logic mc);
    logic [1:0] st;
    load(m, 16'(p), 16'(s));
    do_cmd({(mc ? TBL_MC : TBL_UC), OP_WRITE}, st);
    check(16'(st), 16'(ST_OK));
    mdl[m] = {1'b0, mc, mc | s, p};
  endtask
  task automatic search(input logic [47:0] m, input logic mc, output logic [15:0] idx);
    logic [1:0] st;
    logic [15:0] v;
    load(m, 16'h0000, 16'h0000);
    do_cmd({(mc ? TBL_MC : TBL_UC), OP_SEARCH}, st);
    idx = 16'h0000;
    if (!mdl.exists(m)) begin
      check(16'(st), 16'(ST_NOT_FOUND));
    end else begin
      check(16'(st), 16'(ST_OK));
      host.rd(PORT_OFS, v);
      check(v & 16'h0007, 16'(mdl[m][2:0]));
      host.rd(ATTR_OFS, v);
      if (mc) check(v & 16'h1000, {3'h0, mdl[m][5], 12'h000});
      else check(v & 16'h0001, 16'(mdl[m][3]));
      host.rd(MAC_LO_OFS, idx);
    end
  endtask
  task automatic snoop(input logic j, input logic [47:0] m, input logic [2:0] p);
    int n;
    @(posedge clk);
    #1;
    if (j) begin
      jmac = m;
      jport = p;
      jreq = 1'b1;
    end else begin
      lmac = m;
      lport = p;
      lreq = 1'b1;
    end
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(16'(ready), 16'h0001);
    if (ready !== 1'b1) print_verdict();
    @(posedge clk);
    #1;
    jreq = 1'b0;
    lreq = 1'b0;
    if (!j) mdl[m] = {3'b000, p};
    else if (ig_used < IG_ENTRIES) begin
      mdl[m] = {3'b111, p};
      ig_used++;
    end
  endtask
  initial begin
    logic [47:0] m [4];
    logic [15:0] v, idx;
    logic [1:0] st;
    logic [4:0] bad [6];
    bad = '{5'h00, 5'h06, 5'h07, 5'h19, 5'h13, 5'h15};
    rst_b = 1'b0;
    lreq = 1'b0;
    jreq = 1'b0;
    hw_en = 1'b0;
    lmac = 48'h0;
    jmac = 48'h0;
    lport = 3'h0;
    jport = 3'h0;
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    idle_or_quit();
    host.rd(CSR_OFS, v);
    check(v, {11'h000, CMD_RESET});
    host.rd(PORT_OFS, v);
    check(v, DATA_RESET);
    host.rd(10'h2B6, v);
    check(v, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      new_mac(m[i]);
      write_entry(m[i], seed[2:0], seed[3], 1'b0);
    end
    new_mac(m[3]);
    search(m[3], 1'b0, idx);
    search(m[0], 1'b0, idx);
    host.wr(MAC_LO_OFS, idx);
    do_cmd({TBL_UC, OP_READ}, st);
    check(16'(st), 16'(ST_OK));
    host.rd(PORT_OFS, v);
    check(v & 16'h0007, 16'(mdl[m[0]][2:0]));
    for (int k = 0; k < 3; k++) begin
      host.rd(MAC_LO_OFS + 10'(k), v);
      check(v, m[0][16*k +: 16]);
    end
    $display("test write search read done");
    load(m[3], 16'h0000, 16'h0000);
    host.wr(CSR_OFS, {11'h000, TBL_UC, OP_SEARCH});
    host.wr(CSR_OFS, {11'h000, TBL_UC, OP_DELETE});
    host.wr(MAC_LO_OFS, ~m[3][15:0]);
    idle_or_quit();
    host.rd(CSR_OFS, v);
    check(v, {1'b0, ST_NOT_FOUND, 8'h00, TBL_UC, OP_SEARCH});
    host.rd(MAC_LO_OFS, v);
    check(v, m[3][15:0]);
    load(m[1], 16'h0000, 16'h0000);
    do_cmd({TBL_UC, OP_DELETE}, st);
    check(16'(st), 16'(ST_OK));
    mdl.delete(m[1]);
    search(m[1], 1'b0, idx);
    foreach (bad[k]) begin
      do_cmd(bad[k], st);
      check(16'(st), 16'(ST_REJECT));
    end
    $display("test busy delete reject done");
    new_mac(m[3]);
    snoop(1'b0, m[3], 3'h5);
    search(m[3], 1'b0, idx);
    new_mac(m[0]);
    m[0][40] = 1'b1;
    write_entry(m[0], 3'h3, 1'b0, 1'b1);
    search(m[0], 1'b1, idx);
    // a join held while snooping is off must leave the table alone
    new_mac(m[1]);
    m[1][40] = 1'b1;
    jmac = m[1];
    jreq = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    jreq = 1'b0;
    search(m[1], 1'b1, idx);
    hw_en = 1'b1;
    for (int i = 0; i < 33; i++) begin
      new_mac(m[1]);
      m[1][40] = 1'b1;
      if (i == 0) m[2] = m[1];
      snoop(1'b1, m[1], 3'(i + 1));
    end
    check(16'(ig_full), 16'h0001);
    search(m[1], 1'b1, idx);
    search(m[2], 1'b1, idx);
    // sixth insert since reset: three host writes, one learn, one multicast write
    check(idx, 16'h0005);
    host.wr(MAC_LO_OFS, 16'h0000);
    do_cmd({TBL_IG, OP_READ}, st);
    check(16'(st), 16'(ST_OK));
    host.rd(PORT_OFS, v);
    check(v & 16'h0007, 16'h0001);
    host.rd(MAC_LO_OFS, v);
    check(v & 16'h07FF, 16'h0005);
    host.rd(MAC_MID_OFS, v);
    check(v & 16'h0007, 16'(IG_VALID_INIT));
    host.rd(MAC_HI_OFS, v);
    check(v & 16'h003F, 16'(IG_TIMER_INIT));
    host.wr(MAC_LO_OFS, idx);
    do_cmd({TBL_MC, OP_READ}, st);
    check(16'(st), 16'(ST_OK));
    host.rd(ATTR_OFS, v);
    check(v & 16'h1000, 16'h1000);
    do_cmd({TBL_IG, OP_WRITE}, st);
    check(16'(st), 16'(ST_FULL));
    host.wr(MAC_LO_OFS, 16'h0000);
    do_cmd({TBL_IG, OP_DELETE}, st);
    check(16'(st), 16'(ST_OK));
    check(16'(ig_full), 16'h0000);
    $display("test learn join membership done");
    do_cmd({TBL_UC, OP_CLEAR}, st);
    check(16'(st), 16'(ST_OK));
    mdl.delete();
    search(m[3], 1'b0, idx);
    $display("test clear done");
    print_verdict();
  end
endmodule
